/* design/cil_defines.svh */
// register offsets, field positions and reset values of the interrupt gate
// assumes inclusion by bare name from the package and the design module
`ifndef CIL_DEFINES_SVH
`define CIL_DEFINES_SVH
`define CIL_OFF_SOURCE_ENABLE 12'h054
`define CIL_OFF_LINE_ROUTING 12'h058
`define CIL_OFF_OUTPUT_GATE 12'h05c
`define CIL_FLAG_MSB 29
`define CIL_FLAG_MASK 32'h3fffffff
`define CIL_GATE_MASK 32'h00000003
`define CIL_LINE0_BIT 0
`define CIL_LINE1_BIT 1
`define CIL_ERR_LSB 22
`define CIL_MEM_LSB 16
`define CIL_TX_LSB 8
`define CIL_RXQ1_LSB 4
`define CIL_RXQ0_LSB 0
`define CIL_RESET_VALUE 32'h00000000
`endif

/* design/cil_irq_gate.sv */
// interrupt enable, line routing and line gating with an apb register slave
// assumes flags arrive as levels on mclk from the interrupt flag register
// assumes an apb master that keeps each request until pready
//
// Operation
// - flag signalled only while its enable set
// - error flag enables at bits 29..22
// - memory and timing enables at bits 21..16
// - transmit enables at bits 15..8
// - receive queue 1 bits 7..4, queue 0 3..0
// - route bit 0 line 0, 1 line 1
// - line asserts only when its gate set
// - route bits align with flag and enable bits
// - bits 31,30 read zero, others reset zero
// - gate register bit0 line0, bit1 line1
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`include "cil_defines.svh"

module cil_irq_gate
  import cil_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [29:0] irqFlags,
  output logic irq_out_line0,
  output logic irq_out_line1
);

  ////////////////////////////////////////////////////////////////////////////
  // register storage

  logic [31:0] irq_source_enable; // per flag enable
  logic [31:0] irq_line_routing; // per flag line choice
  logic [31:0] irq_output_gate; // line gates
  // next values of the registers above
  logic [31:0] next_irq_source_enable;
  logic [31:0] next_irq_line_routing;
  logic [31:0] next_irq_output_gate;
  // next values of the bus answer and the lines
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic next_irq_out_line0;
  logic next_irq_out_line1;

  // byte lane merge of a write under a writable mask
  function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] res;
    // start from the stored word
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    // masked bits always read back zero
    laneMerge = res & mask;
  endfunction

  // offset decode, true when address maps a register
  function automatic logic isMapped(input logic [11:0] a);
    isMapped = (a == `CIL_OFF_SOURCE_ENABLE) || (a == `CIL_OFF_LINE_ROUTING) || (a == `CIL_OFF_OUTPUT_GATE);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, one wait-free access phase

  logic setupPhase; // setup cycle seen
  assign setupPhase = psel && !penable;

  // completing edge of a transfer
  logic accessDone; // access phase with pready high
  assign accessDone = psel && penable && pready;

  // next register and bus answer values
  always_comb
  begin
    // hold the registers and read data, drop pready and pslverr, unless a transfer says otherwise
    next_irq_source_enable = irq_source_enable;
    next_irq_line_routing = irq_line_routing;
    next_irq_output_gate = irq_output_gate;
    next_prdata = prdata;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    if (setupPhase)
    begin
      // answer in the access phase that follows
      next_pready = 1'b1;
      next_pslverr = !isMapped(paddr);
      next_prdata = 32'h00000000;
      // read data latched at the setup edge
      if (!pwrite)
      begin
        case (paddr)
          `CIL_OFF_SOURCE_ENABLE: next_prdata = irq_source_enable;
          `CIL_OFF_LINE_ROUTING: next_prdata = irq_line_routing;
          `CIL_OFF_OUTPUT_GATE: next_prdata = irq_output_gate;
          default: next_prdata = 32'h00000000;
        endcase
      end
    end
    if (accessDone && pwrite)
    begin
      // write takes effect at the completing edge
      case (paddr)
        `CIL_OFF_SOURCE_ENABLE:
          next_irq_source_enable = laneMerge(irq_source_enable, pwdata, pstrb, `CIL_FLAG_MASK);
        `CIL_OFF_LINE_ROUTING:
          next_irq_line_routing = laneMerge(irq_line_routing, pwdata, pstrb, `CIL_FLAG_MASK);
        `CIL_OFF_OUTPUT_GATE:
          next_irq_output_gate = laneMerge(irq_output_gate, pwdata, pstrb, `CIL_GATE_MASK);
        default:
          next_irq_output_gate = irq_output_gate;
      endcase
    end
  end

  // register the bus side state
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      // everything disabled and routed to line 0
      irq_source_enable <= `CIL_RESET_VALUE;
      irq_line_routing <= `CIL_RESET_VALUE;
      irq_output_gate <= `CIL_RESET_VALUE;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      // take the next values
      irq_source_enable <= next_irq_source_enable;
      irq_line_routing <= next_irq_line_routing;
      irq_output_gate <= next_irq_output_gate;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt routing

  cil_flags_type enabledFlags; // flags passing their enable
  cil_flags_type toLine1; // enabled flags routed to line 1
  cil_flags_type toLine0; // enabled flags routed to line 0

  // gate and steer every flag
  always_comb
  begin
    enabledFlags = irqFlags & irq_source_enable[`CIL_FLAG_MSB:0];
    toLine1 = enabledFlags & irq_line_routing[`CIL_FLAG_MSB:0];
    toLine0 = enabledFlags & ~irq_line_routing[`CIL_FLAG_MSB:0];
    // or over each line's flags, then its gate
    next_irq_out_line0 = (|toLine0) && irq_output_gate[`CIL_LINE0_BIT];
    next_irq_out_line1 = (|toLine1) && irq_output_gate[`CIL_LINE1_BIT];
  end

  // register the interrupt lines
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      // both lines low in reset
      irq_out_line0 <= 1'b0;
      irq_out_line1 <= 1'b0;
    end
    else
    begin
      // lines follow the gated or one edge late
      irq_out_line0 <= next_irq_out_line0;
      irq_out_line1 <= next_irq_out_line1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // line gates: a gated-off line stays low
  chk_line0_gating: assert property (@(posedge mclk) disable iff (!arst_n)
    (!irq_output_gate[`CIL_LINE0_BIT]) |=> !irq_out_line0)
    else $error("line 0 asserted while gated off");
  chk_line1_gating: assert property (@(posedge mclk) disable iff (!arst_n)
    (!irq_output_gate[`CIL_LINE1_BIT]) |=> !irq_out_line1)
    else $error("line 1 asserted while gated off");

  // no enabled flag, no interrupt
  chk_disabled_flags: assert property (@(posedge mclk) disable iff (!arst_n)
    ((irqFlags & irq_source_enable[29:0]) == 30'h0) |=> !irq_out_line0 && !irq_out_line1)
    else $error("interrupt without enabled flag");

  // steering of enabled flags to their line
  chk_route_line1: assert property (@(posedge mclk) disable iff (!arst_n)
    (|(irqFlags & irq_source_enable[29:0] & irq_line_routing[29:0]) && irq_output_gate[1]) |=> irq_out_line1)
    else $error("flag routed to line 1 not signalled");
  chk_route_line0: assert property (@(posedge mclk) disable iff (!arst_n)
    (|(irqFlags & irq_source_enable[29:0] & ~irq_line_routing[29:0]) && irq_output_gate[0]) |=> irq_out_line0)
    else $error("flag routed to line 0 not signalled");

  // a line with nothing routed to it stays quiet
  chk_line0_quiet: assert property (@(posedge mclk) disable iff (!arst_n)
    ((irqFlags & irq_source_enable[29:0] & ~irq_line_routing[29:0]) == 30'h0) |=> !irq_out_line0)
    else $error("line 0 raised without a flag routed there");
  chk_line1_quiet: assert property (@(posedge mclk) disable iff (!arst_n)
    ((irqFlags & irq_source_enable[29:0] & irq_line_routing[29:0]) == 30'h0) |=> !irq_out_line1)
    else $error("line 1 raised without a flag routed there");

  // field groups, each through its own enable and route bits
  chk_err_group: assert property (@(posedge mclk) disable iff (!arst_n)
    (|(irqFlags[`CIL_FLAG_MSB:`CIL_ERR_LSB] & irq_source_enable[`CIL_FLAG_MSB:`CIL_ERR_LSB]
      & irq_line_routing[`CIL_FLAG_MSB:`CIL_ERR_LSB]) && irq_output_gate[`CIL_LINE1_BIT]) |=> irq_out_line1)
    else $error("error group flag not on line 1");
  chk_mem_group: assert property (@(posedge mclk) disable iff (!arst_n)
    (|(irqFlags[`CIL_ERR_LSB-1:`CIL_MEM_LSB] & irq_source_enable[`CIL_ERR_LSB-1:`CIL_MEM_LSB]
      & irq_line_routing[`CIL_ERR_LSB-1:`CIL_MEM_LSB]) && irq_output_gate[`CIL_LINE1_BIT]) |=> irq_out_line1)
    else $error("memory group flag not on line 1");
  chk_tx_group: assert property (@(posedge mclk) disable iff (!arst_n)
    (|(irqFlags[`CIL_MEM_LSB-1:`CIL_TX_LSB] & irq_source_enable[`CIL_MEM_LSB-1:`CIL_TX_LSB]
      & ~irq_line_routing[`CIL_MEM_LSB-1:`CIL_TX_LSB]) && irq_output_gate[`CIL_LINE0_BIT]) |=> irq_out_line0)
    else $error("transmit group flag not on line 0");
  chk_rxq1_group: assert property (@(posedge mclk) disable iff (!arst_n)
    (|(irqFlags[`CIL_TX_LSB-1:`CIL_RXQ1_LSB] & irq_source_enable[`CIL_TX_LSB-1:`CIL_RXQ1_LSB]
      & ~irq_line_routing[`CIL_TX_LSB-1:`CIL_RXQ1_LSB]) && irq_output_gate[`CIL_LINE0_BIT]) |=> irq_out_line0)
    else $error("queue 1 flag not on line 0");
  chk_rxq0_group: assert property (@(posedge mclk) disable iff (!arst_n)
    (|(irqFlags[`CIL_RXQ1_LSB-1:`CIL_RXQ0_LSB] & irq_source_enable[`CIL_RXQ1_LSB-1:`CIL_RXQ0_LSB]
      & irq_line_routing[`CIL_RXQ1_LSB-1:`CIL_RXQ0_LSB]) && irq_output_gate[`CIL_LINE1_BIT]) |=> irq_out_line1)
    else $error("queue 0 flag not on line 1");

  // reserved bits and reset values
  chk_reserved_zero: assert property (@(posedge mclk) disable iff (!arst_n)
    irq_source_enable[31:30] == 2'b00 && irq_line_routing[31:30] == 2'b00 && irq_output_gate[31:2] == 30'h0)
    else $error("reserved bits not zero");
  chk_reset_values: assert property (@(posedge mclk)
    !arst_n |-> irq_source_enable == `CIL_RESET_VALUE && irq_line_routing == `CIL_RESET_VALUE
      && irq_output_gate == `CIL_RESET_VALUE && !irq_out_line0 && !irq_out_line1)
    else $error("state not cleared in reset");

  // bus answer timing and error reporting
  chk_ready_timing: assert property (@(posedge mclk) disable iff (!arst_n)
    (psel && !penable) |=> pready ##1 !pready)
    else $error("apb answer not one cycle after setup");
  chk_ready_source: assert property (@(posedge mclk) disable iff (!arst_n)
    pready |-> $past(psel && !penable))
    else $error("pready without a setup cycle");
  chk_pready_pulse: assert property (@(posedge mclk) disable iff (!arst_n)
    pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_error_with_ready: assert property (@(posedge mclk) disable iff (!arst_n)
    pslverr |-> pready)
    else $error("pslverr without pready");
  chk_prdata_hold: assert property (@(posedge mclk) disable iff (!arst_n)
    !setupPhase |=> $stable(prdata))
    else $error("read data changed outside a setup edge");
  chk_unmapped_err: assert property (@(posedge mclk) disable iff (!arst_n)
    (psel && !penable && !isMapped(paddr)) |=> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");
  chk_pslverr_mapped: assert property (@(posedge mclk) disable iff (!arst_n)
    (psel && !penable && isMapped(paddr)) |=> !pslverr)
    else $error("mapped access refused");

  // read data follows the stored registers
  chk_read_enable: assert property (@(posedge mclk) disable iff (!arst_n)
    (psel && !penable && !pwrite && paddr == `CIL_OFF_SOURCE_ENABLE) |=> prdata == $past(irq_source_enable))
    else $error("enable read data wrong");
  chk_read_routing: assert property (@(posedge mclk) disable iff (!arst_n)
    (psel && !penable && !pwrite && paddr == `CIL_OFF_LINE_ROUTING) |=> prdata == $past(irq_line_routing))
    else $error("routing read data wrong");
  chk_read_gate: assert property (@(posedge mclk) disable iff (!arst_n)
    (psel && !penable && !pwrite && paddr == `CIL_OFF_OUTPUT_GATE) |=> prdata == $past(irq_output_gate))
    else $error("gate read data wrong");

  // writes land at the completing edge only
  chk_write_effect: assert property (@(posedge mclk) disable iff (!arst_n)
    (psel && penable && pready && pwrite && paddr == `CIL_OFF_SOURCE_ENABLE && pstrb == 4'hf)
    |=> irq_source_enable == ($past(pwdata) & `CIL_FLAG_MASK))
    else $error("enable write not stored");
  chk_write_routing: assert property (@(posedge mclk) disable iff (!arst_n)
    (accessDone && pwrite && paddr == `CIL_OFF_LINE_ROUTING && pstrb == 4'hf)
    |=> irq_line_routing == ($past(pwdata) & `CIL_FLAG_MASK))
    else $error("routing write not stored");
  chk_write_gate: assert property (@(posedge mclk) disable iff (!arst_n)
    (accessDone && pwrite && paddr == `CIL_OFF_OUTPUT_GATE && pstrb == 4'hf)
    |=> irq_output_gate == ($past(pwdata) & `CIL_GATE_MASK))
    else $error("gate write not stored");
  chk_strobe_keep: assert property (@(posedge mclk) disable iff (!arst_n)
    (accessDone && pwrite && paddr == `CIL_OFF_SOURCE_ENABLE && !pstrb[0])
    |=> irq_source_enable[7:0] == $past(irq_source_enable[7:0]))
    else $error("unstrobed lane changed");
  chk_read_no_write: assert property (@(posedge mclk) disable iff (!arst_n)
    (psel && penable && !pwrite)
    |=> $stable(irq_source_enable) && $stable(irq_line_routing) && $stable(irq_output_gate))
    else $error("register changed by a read");

endmodule

/* design/cil_pkg.sv */
// types of the interrupt enable and line select block
// assumes the defines header lies on the include path
package cil_pkg;
  `include "cil_defines.svh"
  // flag vector, one bit per interrupt flag
  typedef logic [`CIL_FLAG_MSB:0] cil_flags_type;
  // apb access phase of the slave
  typedef enum logic [1:0] {CIL_IDLE, CIL_ACCESS} cil_apb_state_type;
endpackage

/* dv/cil_host_model.sv */
// host side of the interrupt lines: samples both lines each edge
// assumes lines are registered on mclk by the interrupt gate
`timescale 1ns/1ps
module cil_host_model
(
  input wire logic mclk,
  input wire logic irqLine0,
  input wire logic irqLine1,
  output logic [1:0] seen
);
  // cpu view of the lines, one edge late
  always_ff @(posedge mclk)
  begin
    seen <= {irqLine1, irqLine0};
  end
endmodule

/* dv/tb_top.sv */
// testbench for the interrupt gate: apb registers and line routing
// assumes design files and host model are compiled first
`timescale 1ns/1ps
module tb_top;
  logic mclk = 1'b0;
  logic arst_n = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  cil_pkg::cil_flags_type irqFlags = '0;
  logic irqLine0;
  logic irqLine1;
  logic [1:0] hostSeen;
  logic [31:0] rdData;
  logic rdErr;
  int error_cnt = 0;
  int n_tests = 0;
  //////////////////////////////////////////
  always #5 mclk = ~mclk;
  cil_irq_gate dut_u (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irqFlags(irqFlags), .irq_out_line0(irqLine0), .irq_out_line1(irqLine1));
  cil_host_model host_u (.mclk(mclk), .irqLine0(irqLine0), .irqLine1(irqLine1), .seen(hostSeen));
  //////////////////////////////////////////
  // compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer, bounded wait for pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int k;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge mclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
    begin
      error_cnt++;
      results();
    end
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // host view of both lines after settling
  task automatic lines(input logic [1:0] exp);
    repeat (3) @(posedge mclk);
    check({30'h0, hostSeen}, {30'h0, exp});
  endtask
  //////////////////////////////////////////
  task automatic t_reset();
    logic [11:0] offs [3] = '{12'h054, 12'h058, 12'h05c};
    lines(2'b00);
    foreach (offs[i])
    begin
      apb(1'b0, offs[i], 32'h0, 4'hf);
      check(rdData, 32'h00000000);
    end
    $display("reset values done");
  endtask
  task automatic t_rw();
    logic [11:0] offs [3] = '{12'h054, 12'h058, 12'h05c};
    logic [31:0] msk [3] = '{32'h3fffffff, 32'h3fffffff, 32'h00000003};
    foreach (offs[i])
    begin
      apb(1'b1, offs[i], 32'hffffffff, 4'hf);
      apb(1'b0, offs[i], 32'h0, 4'hf);
      check(rdData, msk[i]);
    end
    apb(1'b1, 12'h054, 32'h0, 4'h2);
    apb(1'b0, 12'h054, 32'h0, 4'hf);
    check(rdData, 32'h3fff00ff);
    apb(1'b0, 12'h060, 32'h0, 4'hf);
    check({31'h0, rdErr}, 32'h1);
    check(rdData, 32'h0);
    $display("register access done");
  endtask
  // enable bits at both ends of every field, plus bit 17, each alone, routed by its own route bit
  task automatic t_route();
    int bits [11] = '{29, 22, 21, 17, 16, 15, 8, 7, 4, 3, 0};
    foreach (bits[i])
    begin
      apb(1'b1, 12'h054, 32'h1 << bits[i], 4'hf);
      apb(1'b1, 12'h058, (bits[i] % 2) ? 32'h1 << bits[i] : 32'h0, 4'hf);
      irqFlags <= ~(30'h1 << bits[i]);
      lines(2'b00);
      irqFlags <= '1;
      lines((bits[i] % 2) ? 2'b10 : 2'b01);
    end
    $display("routing done");
  endtask
  task automatic t_gate();
    apb(1'b1, 12'h054, 32'h3, 4'hf);
    apb(1'b1, 12'h058, 32'h2, 4'hf);
    lines(2'b11);
    apb(1'b1, 12'h05c, 32'h2, 4'hf);
    lines(2'b10);
    apb(1'b1, 12'h05c, 32'h1, 4'hf);
    lines(2'b01);
    apb(1'b1, 12'h05c, 32'h0, 4'hf);
    lines(2'b00);
    $display("line gates done");
  endtask
  // reset in mid-run clears the enable and routing registers and drops both lines
  task automatic t_midreset();
    apb(1'b1, 12'h05c, 32'h3, 4'hf);
    lines(2'b11);
    @(posedge mclk);
    arst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    lines(2'b00);
    apb(1'b0, 12'h054, 32'h0, 4'hf);
    check(rdData, 32'h00000000);
    apb(1'b0, 12'h058, 32'h0, 4'hf);
    check(rdData, 32'h00000000);
    $display("mid-run reset done");
  endtask
  //////////////////////////////////////////
  task automatic results();
    $display("comparisons=%0d mismatches=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    arst_n <= 1'b0;
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    t_reset();
    t_rw();
    t_route();
    t_gate();
    t_midreset();
    results();
  end
endmodule
